// *** core/sixteen_bit_timer_counter.sv ***
// Module: 16-bit timer/counter with Avalon-MM register access
//
// Notes on behaviour
// - Wide mode: count in two byte accesses, high byte via buffer
// - Byte mode: each byte accessed directly
// - Prescale select: 00/01/10/11 give 1/2/4/8
// - Crystal oscillator enabled only by its bit
// - External clock synchronised unless sync disabled
// - Internal source ignores sync disable bit
// - Source 0 is Fosc/4, 1 external pin or oscillator
// - Counts only while run bit set
// - Three modes: timer, sync, async counter
// - Timer mode ticks once per instruction cycle
// - External edge from pin or oscillator
// - Oscillator enable forces both pins input
// - Compare unit reset input clears count
// - Oscillator and async count survive sleep
// - Count wraps FFFF to 0, sets overflow
// - Wide low read latches high byte
// - Wide low write loads high from buffer
// - Only low byte writes clear prescaler
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sixteen_bit_timer_counter
    import timer_one_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Pins and neighbours
    input  wire logic        extCountPin,
    input  wire logic        oscClockIn,
    input  wire logic [1:0]  portDirectionBits,
    input  wire logic        compareReset,
    input  wire logic        sleepMode,
    output logic             oscEnable,
    output logic [1:0]       pinOutputEnable,
    output logic             overflowFlag,
    output logic [15:0]      countValue
);
    // Register state
    logic [7:0]  control_q;
    logic [15:0] count_q;
    logic [7:0]  highBuffer_q;
    logic        overflow_q;
    logic [31:0] readdata_q;
    logic        ack_q;

    // Control fields
    logic        wideAccess;
    logic [1:0]  prescSelect;
    logic        syncDisable;
    logic        clockSource;
    logic        runEnable;

    // Bus decode
    logic        request;
    logic        accept;
    logic        capture;
    logic        writeAccept;
    logic        hitControl;
    logic        hitLow;
    logic        hitHigh;
    logic        hitStatus;

    // Tick path
    logic [1:0]  instrDiv_q;
    logic        instrTick;
    logic        extLevel;
    logic        extEdge;
    logic        sourceTick;
    logic        countTick;
    logic        wrap;
    mode_t       mode;

    prescale_if presc ();

    // Field extraction
    assign wideAccess  = control_q[BIT_WIDE_ACCESS];
    assign prescSelect = control_q[BIT_PRESC_HI:BIT_PRESC_LO];
    assign oscEnable   = control_q[BIT_OSC_ENABLE];
    assign syncDisable = control_q[BIT_SYNC_DIS];
    assign clockSource = control_q[BIT_CLK_SOURCE];
    assign runEnable   = control_q[BIT_RUN];

    // Address decode
    assign hitControl = (address == ADDR_CONTROL);
    assign hitLow     = (address == ADDR_LOW);
    assign hitHigh    = (address == ADDR_HIGH);
    assign hitStatus  = (address == ADDR_STATUS);

    // One wait cycle: data is captured first, then the request accepted
    assign request     = read || write;
    assign capture     = request && !ack_q;
    assign accept      = request && ack_q;
    assign writeAccept = write && ack_q;
    assign waitrequest = request && !ack_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= capture;
        end
    end

    // Read data mux, registered at the capture edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata_q <= 32'h0000_0000;
        end else if (capture && read) begin
            readdata_q <= 32'h0000_0000;
            if (hitControl) begin
                // Unused bit always reads back as zero
                readdata_q[7:0] <= control_q;
            end else if (hitLow) begin
                readdata_q[7:0] <= count_q[7:0];
            end else if (hitHigh) begin
                // Wide mode reads the buffer, byte mode the live byte
                readdata_q[7:0] <= wideAccess ? highBuffer_q
                                              : count_q[15:8];
            end else if (hitStatus) begin
                readdata_q[BIT_OVERFLOW]    <= overflow_q;
                readdata_q[BIT_OSC_RUNNING] <= oscEnable;
            end
        end
    end

    assign readdata = readdata_q;

    // Control register; bit 6 never stores a one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_q <= CONTROL_RESET;
        end else if (writeAccept && hitControl) begin
            control_q                <= writedata[7:0];
            control_q[BIT_UNUSED]    <= 1'b0;
        end
    end

    // High byte buffer: loaded by wide low reads and wide high writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            highBuffer_q <= 8'h00;
        end else if (wideAccess && capture && read && hitLow) begin
            // Snapshot taken with the low byte so no rollover splits them
            highBuffer_q <= count_q[15:8];
        end else if (wideAccess && writeAccept && hitHigh) begin
            highBuffer_q <= writedata[7:0];
        end
    end

    // Operating mode from source and sync bits
    always_comb begin
        if (!clockSource) begin
            mode = MODE_TIMER;
        end else if (syncDisable) begin
            mode = MODE_ASYNC_COUNT;
        end else begin
            mode = MODE_SYNC_COUNT;
        end
    end

    // Instruction cycle enable: one pulse every INSTR_DIV core clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instrDiv_q <= 2'h0;
        end else if (instrDiv_q == 2'(INSTR_DIV - 1)) begin
            instrDiv_q <= 2'h0;
        end else begin
            instrDiv_q <= instrDiv_q + 2'h1;
        end
    end

    assign instrTick = (instrDiv_q == 2'(INSTR_DIV - 1));

    // External source: oscillator output when enabled, else the pin
    assign extLevel = oscEnable ? oscClockIn : extCountPin;

    edge_catcher u_edge (
        .clk        (clk),
        .rst        (rst),
        .pinLevel   (extLevel),
        .bypassSync (syncDisable),
        .risePulse  (extEdge)
    );

    // Source select; in sleep only the async counter keeps running
    always_comb begin
        unique case (mode)
            MODE_TIMER:       sourceTick = instrTick && !sleepMode;
            MODE_SYNC_COUNT:  sourceTick = extEdge && !sleepMode;
            MODE_ASYNC_COUNT: sourceTick = extEdge;
        endcase
    end

    // Prescaler runs only while counting is enabled
    assign presc.rawTick = sourceTick && runEnable;
    assign presc.select  = prescSelect;
    assign presc.clear   = writeAccept && hitLow;

    input_prescaler u_presc (
        .clk   (clk),
        .rst   (rst),
        .presc (presc)
    );

    assign countTick = presc.outTick;
    assign wrap      = countTick && (count_q == COUNT_MAX);

    // Counter: bus writes win over compare reset, which wins over ticks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= COUNT_RESET;
        end else if (writeAccept && hitLow) begin
            count_q[7:0] <= writedata[7:0];
            if (wideAccess) begin
                count_q[15:8] <= highBuffer_q;
            end
        end else if (writeAccept && hitHigh && !wideAccess) begin
            count_q[15:8] <= writedata[7:0];
        end else if (compareReset) begin
            count_q <= COUNT_RESET;
        end else if (countTick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Overflow flag: write one to clear, a new wrap wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_q <= 1'b0;
        end else if (wrap && !(writeAccept && (hitLow || hitHigh))) begin
            overflow_q <= 1'b1;
        end else if (writeAccept && hitStatus && writedata[BIT_OVERFLOW]) begin
            overflow_q <= 1'b0;
        end
    end

    assign overflowFlag = overflow_q;
    assign countValue   = count_q;

    // Pin drivers: oscillator forces both pins to input
    always_comb begin
        if (oscEnable) begin
            pinOutputEnable = 2'b00;
        end else begin
            pinOutputEnable = ~portDirectionBits;
        end
    end

    // Start-up delay is software's job; no wait is enforced here

endmodule // sixteen_bit_timer_counter

// *** common/timer_one_pkg.sv ***
// Package: register map, field positions and constants of the 16-bit timer
package timer_one_pkg;

    // Byte addresses on the register bus
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_LOW     = 4'h4;
    localparam logic [3:0] ADDR_HIGH    = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'hc;

    // Control register field positions
    localparam int BIT_WIDE_ACCESS = 7;
    localparam int BIT_UNUSED      = 6;
    localparam int BIT_PRESC_HI    = 5;
    localparam int BIT_PRESC_LO    = 4;
    localparam int BIT_OSC_ENABLE  = 3;
    localparam int BIT_SYNC_DIS    = 2;
    localparam int BIT_CLK_SOURCE  = 1;
    localparam int BIT_RUN         = 0;

    // Status register field positions
    localparam int BIT_OVERFLOW    = 0;
    localparam int BIT_OSC_RUNNING = 1;

    // Values after reset
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;

    // Core clock cycles per instruction cycle
    localparam int INSTR_DIV = 4;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_SYNC_COUNT,
        MODE_ASYNC_COUNT
    } mode_t;

endpackage

// *** common/prescale_if.sv ***
// Interface: raw count ticks into the prescaler and divided ticks out
`timescale 1ns/1ps
interface prescale_if;
    logic       rawTick;
    logic       clear;
    logic [1:0] select;
    logic       outTick;

    modport source (output rawTick, output clear, output select,
                    input outTick);
    modport divider (input rawTick, input clear, input select,
                     output outTick);
endinterface

// *** core/input_prescaler.sv ***
// Module: 1/2/4/8 prescaler on the raw count ticks
`timescale 1ns/1ps
module input_prescaler
    import timer_one_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    prescale_if.divider presc
);
    logic [2:0] count_q;
    logic [2:0] limit;

    // Terminal count is 2^select - 1
    assign limit = 3'((4'h1 << presc.select) - 4'h1);
    assign presc.outTick = presc.rawTick && (count_q == limit);

    // Divider counter, cleared by software on demand
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 3'h0;
        end else if (presc.clear) begin
            count_q <= 3'h0;
        end else if (presc.outTick) begin
            count_q <= 3'h0;
        end else if (presc.rawTick) begin
            count_q <= count_q + 3'h1;
        end
    end
endmodule // input_prescaler

// *** core/edge_catcher.sv ***
// Module: rising edge detector with optional two-stage synchroniser
`timescale 1ns/1ps
module edge_catcher (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinLevel,
    input  wire logic bypassSync,
    output logic      risePulse
);
    logic syncA_q;
    logic syncB_q;
    logic prev_q;
    logic chosen;

    // Two flops; the first is seen only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
        end else begin
            syncA_q <= pinLevel;
            syncB_q <= syncA_q;
        end
    end

    // Bypass path trades metastability margin for two cycles less lag
    assign chosen = bypassSync ? pinLevel : syncB_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= chosen;
        end
    end

    assign risePulse = chosen && !prev_q;
endmodule // edge_catcher

// *** testbench/timer_one_asserts.sv ***
// Checker: port-level properties of the 16-bit timer/counter
`timescale 1ns/1ps
module timer_one_asserts
    import timer_one_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [1:0]  portDirectionBits,
    input wire logic        compareReset,
    input wire logic        oscEnable,
    input wire logic [1:0]  pinOutputEnable,
    input wire logic        overflowFlag,
    input wire logic [15:0] countValue
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [7:0] ctrlQ;
    logic       wrCtl;
    assign wrCtl = write && !waitrequest && address == ADDR_CONTROL;

    // Mirror of control, so the run bit can be judged from the ports
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ctrlQ <= CONTROL_RESET;
        else if (wrCtl)
            ctrlQ <= writedata[7:0];
    end

    property p_pinDir;
        pinOutputEnable == (oscEnable ? 2'b00 : ~portDirectionBits);
    endproperty
    property p_oscBit;
        wrCtl |=> oscEnable == $past(writedata[BIT_OSC_ENABLE]);
    endproperty
    property p_clear;
        compareReset && !write |=> countValue == COUNT_RESET;
    endproperty
    // Writes and clears are left out: they may load any value
    property p_hold;
        !ctrlQ[BIT_RUN] && !compareReset && !write |=> $stable(countValue);
    endproperty
    property p_step;
        !$stable(countValue) && !$past(write) && !$past(compareReset)
            |-> countValue == 16'($past(countValue) + 16'h1);
    endproperty
    property p_wrap;
        $past(countValue) == COUNT_MAX && countValue == COUNT_RESET
            && !$past(write) && !$past(compareReset) |-> ##[0:1] overflowFlag;
    endproperty
    property p_unused;
        read && !waitrequest && address == ADDR_CONTROL
            |-> readdata[BIT_UNUSED] == 1'b0;
    endproperty
    property p_waitOnce;
        waitrequest |=> !waitrequest;
    endproperty
    property p_idle;
        !(read || write) |-> !waitrequest;
    endproperty

    a_pinDir: assert property (p_pinDir) else $error("pin enable wrong");
    a_oscBit: assert property (p_oscBit) else $error("osc enable wrong");
    a_clear: assert property (p_clear) else $error("count not cleared");
    a_hold: assert property (p_hold) else $error("count moved stopped");
    a_step: assert property (p_step) else $error("count step wrong");
    a_wrap: assert property (p_wrap) else $error("no overflow flag");
    a_unused: assert property (p_unused) else $error("bit 6 not zero");
    a_waitOnce: assert property (p_waitOnce) else $error("wait too long");
    a_idle: assert property (p_idle) else $error("wait when idle");

    c_wrap: cover property (p_wrap);
    c_clear: cover property (compareReset);
    c_osc: cover property (oscEnable && ctrlQ[BIT_RUN]);
endmodule // timer_one_asserts

bind sixteen_bit_timer_counter timer_one_asserts u_timer_one_asserts (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .portDirectionBits(portDirectionBits), .compareReset(compareReset),
    .oscEnable(oscEnable), .pinOutputEnable(pinOutputEnable),
    .overflowFlag(overflowFlag), .countValue(countValue));

// *** testbench/count_source_model.sv ***
// Model: external count pin and low-power crystal oscillator output
`timescale 1ns/1ps
module count_source_model (
    input  wire logic clk,
    output logic      extCountPin,
    output logic      oscClockIn
);
    // Both sources stand low between bursts; nothing runs free
    initial begin
        extCountPin = 1'b0;
        oscClockIn  = 1'b0;
    end

    // Burst of rising edges, three clocks high and three low
    task automatic pulses(input int n, input bit useOsc);
        repeat (n) begin
            if (useOsc)
                oscClockIn <= 1'b1;
            else
                extCountPin <= 1'b1;
            repeat (3) @(posedge clk);
            oscClockIn <= 1'b0;
            extCountPin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule // count_source_model

// *** testbench/testbench.sv ***
// Testbench: register-level tests of the 16-bit timer/counter
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end end
module testbench
    import timer_one_pkg::*;
;
    logic        clk, rst, read, write, compareReset, sleepMode;
    logic [3:0]  address;
    logic [31:0] writedata, readdata;
    logic [1:0]  portDirectionBits, pinOutputEnable;
    logic        waitrequest, extCountPin, oscClockIn, oscEnable;
    logic        overflowFlag;
    logic [15:0] countValue, c;
    logic [7:0]  v;
    logic [7:0]  mode [3] = '{8'h03, 8'h07, 8'h0f};
    int          n_mismatch, comparisons, n;

    sixteen_bit_timer_counter u_sixteen_bit_timer_counter (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .extCountPin(extCountPin),
        .oscClockIn(oscClockIn), .portDirectionBits(portDirectionBits),
        .compareReset(compareReset), .sleepMode(sleepMode),
        .oscEnable(oscEnable), .pinOutputEnable(pinOutputEnable),
        .overflowFlag(overflowFlag), .countValue(countValue));
    count_source_model u_count_source_model (.clk(clk),
        .extCountPin(extCountPin), .oscClockIn(oscClockIn));

    always #20 clk = ~clk;

    // Bus cycle: hold the request until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
        address <= a;
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, v);
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, v);
        `CHK(v, e)
    endtask
    task automatic pulse_clear;
        compareReset <= 1'b1;
        @(posedge clk);
        compareReset <= 1'b0;
        @(posedge clk);
    endtask
    // Clocks between two count changes, the first one discarded
    task automatic period(output int p);
        repeat (2) begin
            c = countValue;
            p = 0;
            while (countValue === c && p < 100) begin
                @(posedge clk);
                p++;
            end
        end
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs a few hundred clocks
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        clk = 0; rst = 1; read = 0; write = 0; address = 0; writedata = 0;
        compareReset = 0; sleepMode = 0; portDirectionBits = 2'b01;
        n_mismatch = 0; comparisons = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(countValue, COUNT_RESET)
        chk_rd(ADDR_CONTROL, CONTROL_RESET);
        chk_rd(4'h2, 8'h00);
        wr(ADDR_CONTROL, 8'hff);
        chk_rd(ADDR_CONTROL, 8'hbf);
        `CHK(pinOutputEnable, 2'b00)
        wr(ADDR_CONTROL, 8'h00);
        `CHK(pinOutputEnable, 2'b10)
        // Timer mode with sync disable set, every prescale code
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CONTROL, {2'b00, p[1:0], 4'h5});
            period(n);
            `CHK(n, INSTR_DIV << p)
        end
        wr(ADDR_CONTROL, 8'h04);
        c = countValue;
        repeat (40) @(posedge clk);
        `CHK(countValue, c)
        pulse_clear();
        `CHK(countValue, COUNT_RESET)
        // Sync pin, async pin, then oscillator while asleep
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CONTROL, mode[i]);
            wr(ADDR_HIGH, 8'h00);
            wr(ADDR_LOW, 8'h00);
            sleepMode <= (i == 2);
            repeat (20) @(posedge clk);
            u_count_source_model.pulses(i + 3, i == 2);
            repeat (8) @(posedge clk);
            `CHK(countValue, 16'(i + 3))
        end
        `CHK(oscEnable, 1'b1)
        // Sleep must freeze the synchronised counter: edges are refused
        wr(ADDR_CONTROL, 8'h03);
        c = countValue;
        u_count_source_model.pulses(3, 1'b0);
        repeat (8) @(posedge clk);
        `CHK(countValue, c)
        sleepMode <= 1'b0;
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_HIGH, 8'h12);
        `CHK(countValue, 16'h0005)
        wr(ADDR_LOW, 8'h34);
        `CHK(countValue, 16'h1234)
        chk_rd(ADDR_LOW, 8'h34);
        pulse_clear();
        chk_rd(ADDR_HIGH, 8'h12);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_HIGH, 8'hff);
        wr(ADDR_LOW, 8'hfe);
        `CHK(countValue, 16'hfffe)
        chk_rd(ADDR_HIGH, 8'hff);
        wr(ADDR_CONTROL, 8'h01);
        repeat (12) @(posedge clk);
        `CHK(overflowFlag, 1'b1)
        wr(ADDR_CONTROL, 8'h00);
        chk_rd(ADDR_STATUS, 8'h01);
        wr(ADDR_STATUS, 8'h01);
        `CHK(overflowFlag, 1'b0)
        final_report();
    end
endmodule // testbench
